// ---- hw/cmos_share_pkg.sv ----
package cmos_share_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [15:0] addr_t;

	////////////////////////////////////////////////////////////////////////////
	// device register map on the controller bus
	localparam addr_t CTRL_OFFSET = 16'h7FF5;
	localparam addr_t IDX_LOW_OFFSET = 16'h7FF6;
	localparam addr_t DATA_LOW_OFFSET = 16'h7FF7;
	localparam addr_t IDX_HIGH_OFFSET = 16'h7FF8;
	localparam addr_t DATA_HIGH_OFFSET = 16'h7FF9;

	localparam byte_t CTRL_RESET = 8'h80;
	localparam byte_t IDX_RESET = 8'h00;
	localparam byte_t READ_ZERO = 8'h00;

	localparam int SMART_BIT = 7;
	localparam int HREQ_LOW_BIT = 0;
	localparam int CONTROLLER_BANK_REQUEST_LOW_BIT = 1;
	localparam int HREQ_HIGH_BIT = 2;
	localparam int CONTROLLER_BANK_REQUEST_HIGH_BIT = 3;

	localparam int BANK_BITS = 7;
	localparam int CMOS_BYTES = 256;
	localparam byte_t MIRROR_INDEX = 8'h7F;

	////////////////////////////////////////////////////////////////////////////
	// agent registers, avalon word index
	localparam logic [1:0] AVS_CMD = 2'h0;
	localparam logic [1:0] AVS_STATUS = 2'h1;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BANK_POS = 3;
	localparam int CMD_INDEX_LSB = 8;
	localparam int CMD_WDATA_LSB = 16;
	localparam int CMD_SMART_POS = 24;

	localparam int ST_BUSY = 0;
	localparam int ST_FAIL = 1;
	localparam int ST_OWN_LOW = 2;
	localparam int ST_OWN_HIGH = 3;
	localparam int ST_SMART = 4;
	localparam int ST_RDATA_LSB = 8;

	typedef enum logic [2:0] {
		OP_REQUEST,
		OP_RELEASE,
		OP_WRITE,
		OP_READ,
		OP_SMART
	} agent_op_t;

endpackage

// ---- hw/cmos_share_if.sv ----
`timescale 1ns/1ps
interface cmos_share_if;
	cmos_share_pkg::addr_t addr;
	logic wr;
	logic rd;
	cmos_share_pkg::byte_t wdata;
	cmos_share_pkg::byte_t rdata;
	logic rdValid;

	modport device(input addr, input wr, input rd, input wdata, output rdata, output rdValid);
	modport controller(output addr, output wr, output rd, output wdata, input rdata,
		input rdValid);
endinterface

// ---- hw/cmos_share_ctrl_agent.sv ----
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cmos_share_ctrl_agent #(
	parameter int RETRY_MAX = 8 // request attempts before giving up
) (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	cmos_share_if.controller bus, // device register bus
	input wire logic [1:0] avs_address, // avalon word index
	input wire logic avs_read, // avalon read
	input wire logic avs_write, // avalon write
	input wire logic [31:0] avs_writedata, // avalon write data
	output logic [31:0] avs_readdata, // avalon read data
	output logic avs_waitrequest // avalon wait
);
	import cmos_share_pkg::*;

	localparam int RW = $clog2(RETRY_MAX + 1);

	generate
		if (RETRY_MAX < 1) begin : g_bad
			$error("RETRY_MAX must be at least one");
		end
	endgenerate

	typedef enum {
		S_IDLE, S_CTRL_WR, S_CTRL_RD, S_CTRL_WAIT, S_IDX_WR, S_DATA_WR, S_DATA_RD, S_DATA_WAIT
	} state_t;

	state_t state_q, state_d;
	agent_op_t op_q, op_d;
	logic bank_q, bank_d;
	byte_t index_q, index_d, wbyte_q, wbyte_d, rbyte_q, rbyte_d;
	logic [1:0] own_q, own_d;
	logic smart_q, smart_d, fail_q, fail_d;
	logic [RW-1:0] retry_q, retry_d;
	addr_t addr_q, addr_d;
	logic wr_q, wr_d, rd_q, rd_d;
	byte_t wdata_q, wdata_d;
	logic waitreq_q, accept, stall, cmdGo, busy;
	logic [31:0] status, rdata_q, rdata_d;
	byte_t ctrlWord;
	logic grantBit;

	assign busy = state_q != S_IDLE;
	assign cmdGo = avs_write && !waitreq_q && (avs_address == AVS_CMD);
	// commands stall the master rather than being dropped while busy
	assign stall = avs_write && (avs_address == AVS_CMD) && busy;
	assign accept = (avs_read || avs_write) && waitreq_q && !stall;
	assign ctrlWord = {smart_q, 3'b000, own_q[1], 1'b0, own_q[0], 1'b0};
	assign grantBit = bank_q ? bus.rdata[CONTROLLER_BANK_REQUEST_HIGH_BIT] : bus.rdata[CONTROLLER_BANK_REQUEST_LOW_BIT];

	always_comb begin
		status = 32'h0000_0000;
		status[ST_BUSY] = busy;
		status[ST_FAIL] = fail_q;
		status[ST_OWN_LOW] = own_q[0];
		status[ST_OWN_HIGH] = own_q[1];
		status[ST_SMART] = smart_q;
		status[ST_RDATA_LSB +: 8] = rbyte_q;
	end

	assign rdata_d = !accept ? rdata_q : (avs_address == AVS_STATUS) ? status : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		bank_d = bank_q;
		index_d = index_q;
		wbyte_d = wbyte_q;
		rbyte_d = rbyte_q;
		own_d = own_q;
		smart_d = smart_q;
		fail_d = fail_q;
		retry_d = retry_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		unique case (state_q)
			S_IDLE: begin
				if (cmdGo) begin
					op_d = agent_op_t'(avs_writedata[CMD_OP_LSB +: 3]);
					bank_d = avs_writedata[CMD_BANK_POS];
					index_d = avs_writedata[CMD_INDEX_LSB +: 8];
					wbyte_d = avs_writedata[CMD_WDATA_LSB +: 8];
					fail_d = 1'b0;
					retry_d = '0;
					case (avs_writedata[CMD_OP_LSB +: 3])
						OP_REQUEST: begin
							own_d[avs_writedata[CMD_BANK_POS]] = 1'b1;
							state_d = S_CTRL_WR;
						end
						OP_RELEASE: begin
							own_d[avs_writedata[CMD_BANK_POS]] = 1'b0;
							state_d = S_CTRL_WR;
						end
						OP_SMART: begin
							smart_d = avs_writedata[CMD_SMART_POS];
							state_d = S_CTRL_WR;
						end
						OP_WRITE, OP_READ: state_d = S_IDX_WR;
						default: state_d = S_IDLE;
					endcase
				end
			end
			S_CTRL_WR: begin
				wr_d = 1'b1;
				addr_d = CTRL_OFFSET;
				wdata_d = ctrlWord;
				state_d = (op_q == OP_REQUEST) ? S_CTRL_RD : S_IDLE;
			end
			S_CTRL_RD: begin
				rd_d = 1'b1;
				addr_d = CTRL_OFFSET;
				state_d = S_CTRL_WAIT;
			end
			S_CTRL_WAIT: begin
				if (bus.rdValid) begin
					if (grantBit) begin
						state_d = S_IDLE;
					end else if (retry_q == RW'(RETRY_MAX - 1)) begin
						own_d[bank_q] = 1'b0;
						fail_d = 1'b1;
						state_d = S_IDLE;
					end else begin
						retry_d = retry_q + 1'b1;
						state_d = S_CTRL_WR;
					end
				end
			end
			S_IDX_WR: begin
				// index rewritten before every data access
				wr_d = 1'b1;
				addr_d = bank_q ? IDX_HIGH_OFFSET : IDX_LOW_OFFSET;
				wdata_d = index_q;
				state_d = (op_q == OP_WRITE) ? S_DATA_WR : S_DATA_RD;
			end
			S_DATA_WR: begin
				wr_d = 1'b1;
				addr_d = bank_q ? DATA_HIGH_OFFSET : DATA_LOW_OFFSET;
				wdata_d = wbyte_q;
				state_d = S_IDLE;
			end
			S_DATA_RD: begin
				rd_d = 1'b1;
				addr_d = bank_q ? DATA_HIGH_OFFSET : DATA_LOW_OFFSET;
				state_d = S_DATA_WAIT;
			end
			S_DATA_WAIT: begin
				if (bus.rdValid) begin
					rbyte_d = bus.rdata;
					state_d = S_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			op_q <= OP_REQUEST;
			{bank_q, index_q, wbyte_q, rbyte_q, own_q, fail_q, retry_q} <= '0;
			smart_q <= CTRL_RESET[SMART_BIT];
			{addr_q, wr_q, rd_q, wdata_q} <= '0;
			waitreq_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			{bank_q, index_q, wbyte_q, rbyte_q, own_q, fail_q, retry_q} <=
				{bank_d, index_d, wbyte_d, rbyte_d, own_d, fail_d, retry_d};
			smart_q <= smart_d;
			{addr_q, wr_q, rd_q, wdata_q} <= {addr_d, wr_d, rd_d, wdata_d};
			waitreq_q <= !accept;
			rdata_q <= rdata_d;
		end
	end

	assign bus.addr = addr_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign bus.wdata = wdata_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = waitreq_q;

endmodule // cmos_share_ctrl_agent

// ---- hw/cmos_ram_shared_access_arbiter.sv ----
`timescale 1ns/1ps
// Summary of operation
// - controller owns CMOS during reset or supply off
// - smart-host bit one grants host except during reset or supply off
// - otherwise request bits pick owner or none
// - writing smart-host one clears host requests
// - clearing smart-host restores controller request access
// - controller low request refused while host holds
// - host low request refused while controller holds
// - controller high request refused while host holds
// - host high request refused while controller holds
// - low bank 00-7F, high bank 80-FF
// - controller rewrites index after regaining bank
// - each index register addresses its bank
// - index selects location only when controller granted
// - index bit seven ignored in decode
// - location 7F mirrors control, not storage
// - data register accesses indexed byte when granted
module cmos_ram_shared_access_arbiter (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	cmos_share_if.device bus, // controller register bus
	input wire logic resetOutActive, // system reset output asserted
	input wire logic secondarySupplyOn, // secondary supply domain powered
	input wire logic hostReqWr, // host writes its request bits
	input wire logic hostReqLow, // host low bank request value
	input wire logic hostReqHigh, // host high bank request value
	input wire logic hostCmosWr, // host byte write strobe
	input wire logic hostCmosRd, // host byte read strobe
	input wire cmos_share_pkg::byte_t hostCmosAddr, // host byte address
	input wire cmos_share_pkg::byte_t hostCmosWdata, // host write byte
	output cmos_share_pkg::byte_t hostCmosRdata, // host read byte
	output logic hostCmosRdValid, // host read byte valid
	output cmos_share_pkg::byte_t hostCtrlValue, // control register as host sees it
	output logic [1:0] hostGrant, // host owns bank (high, low)
	output logic [1:0] ctrlGrant // controller owns bank (high, low)
);
	import cmos_share_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// control register state
	logic smartHostN_q;
	logic smartHostN_d;
	logic [1:0] controller_bank_request_q;
	logic [1:0] controller_bank_request_d;
	logic [1:0] hReq_q;
	logic [1:0] hReq_d;
	byte_t ctrlValue;

	// per bank decode
	logic [1:0] hostReqBits;
	logic [1:0] kSet;
	logic [1:0] kClr;
	logic [1:0] kTake;
	logic [1:0] hSet;
	logic [1:0] hClr;
	logic [1:0] ctrlOwn;
	logic [1:0] hostOwn;
	logic [1:0] selIdx;
	logic [1:0] selData;
	logic [1:0] dataWr;
	byte_t idx_q [2];
	byte_t cmosAddr [2];
	byte_t dataRead [2];
	byte_t dataRdVal [2];

	// storage, battery backed so it has no reset
	byte_t mem_q [CMOS_BYTES];

	logic ctrlWr;
	logic smartClear;
	logic override;
	logic selCtrl;
	byte_t busRdata_d;
	logic hostBank;
	logic hostAllowed;
	logic hostMirror;
	logic hostWrOk;
	byte_t hostRdata_d;
	byte_t busRdata_q;
	logic busRdValid_q;

	////////////////////////////////////////////////////////////////////////////
	assign selCtrl = bus.addr == CTRL_OFFSET;
	assign ctrlWr = bus.wr && selCtrl;
	assign override = resetOutActive || !secondarySupplyOn;
	assign smartClear = ctrlWr && bus.wdata[SMART_BIT];
	// host requests do not latch while the host ignores the protocol
	assign smartHostN_d = ctrlWr ? bus.wdata[SMART_BIT] : smartHostN_q;
	assign hostReqBits = {hostReqHigh, hostReqLow};

	always_comb begin
		ctrlValue = 8'h00;
		ctrlValue[SMART_BIT] = smartHostN_q;
		ctrlValue[HREQ_LOW_BIT] = hReq_q[0];
		ctrlValue[CONTROLLER_BANK_REQUEST_LOW_BIT] = controller_bank_request_q[0];
		ctrlValue[HREQ_HIGH_BIT] = hReq_q[1];
		ctrlValue[CONTROLLER_BANK_REQUEST_HIGH_BIT] = controller_bank_request_q[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// one slice per bank: 0 covers 00-7F, 1 covers 80-FF
	generate
		for (genvar b = 0; b < 2; b++) begin : g_bank
			localparam int KB = (b == 0) ? CONTROLLER_BANK_REQUEST_LOW_BIT : CONTROLLER_BANK_REQUEST_HIGH_BIT;
			localparam addr_t IDX_OFF = (b == 0) ? IDX_LOW_OFFSET : IDX_HIGH_OFFSET;
			localparam addr_t DATA_OFF = (b == 0) ? DATA_LOW_OFFSET : DATA_HIGH_OFFSET;

			assign kSet[b] = ctrlWr && bus.wdata[KB];
			assign kClr[b] = ctrlWr && !bus.wdata[KB];
			// controller set lands only if host bit is clear now
			assign kTake[b] = kSet[b] && !hReq_q[b];
			assign controller_bank_request_d[b] = kClr[b] ? 1'b0 : (kTake[b] ? 1'b1 : controller_bank_request_q[b]);

			assign hSet[b] = hostReqWr && hostReqBits[b] && !smartHostN_q;
			assign hClr[b] = hostReqWr && !hostReqBits[b];
			// a same-cycle controller set wins the tie
			assign hReq_d[b] = (smartClear || hClr[b]) ? 1'b0 :
				((hSet[b] && !controller_bank_request_q[b] && !kTake[b]) ? 1'b1 : hReq_q[b]);

			assign ctrlOwn[b] = override || (!smartHostN_q && controller_bank_request_q[b]);
			assign hostOwn[b] = !override && (smartHostN_q || hReq_q[b]);

			assign selIdx[b] = bus.addr == IDX_OFF;
			assign selData[b] = bus.addr == DATA_OFF;
			assign cmosAddr[b] = {1'(b), idx_q[b][BANK_BITS-1:0]};
			assign dataWr[b] = bus.wr && selData[b] && ctrlOwn[b] &&
				(cmosAddr[b] != MIRROR_INDEX);
			assign dataRead[b] = (cmosAddr[b] == MIRROR_INDEX) ? ctrlValue :
				mem_q[cmosAddr[b]];
			assign dataRdVal[b] = ctrlOwn[b] ? dataRead[b] : READ_ZERO;

			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					idx_q[b] <= IDX_RESET;
				end else if (bus.wr && selIdx[b]) begin
					idx_q[b] <= bus.wdata;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// host side of the shared storage
	assign hostBank = hostCmosAddr[BANK_BITS];
	assign hostAllowed = hostOwn[hostBank];
	assign hostMirror = hostCmosAddr == MIRROR_INDEX;
	assign hostWrOk = hostCmosWr && hostAllowed && !hostMirror;
	assign hostRdata_d = !hostAllowed ? READ_ZERO : (hostMirror ? ctrlValue :
		mem_q[hostCmosAddr]);

	// refused requests already read back as zero through ctrlValue
	assign busRdata_d = selCtrl ? ctrlValue :
		selIdx[0] ? idx_q[0] :
		selIdx[1] ? idx_q[1] :
		selData[0] ? dataRdVal[0] :
		selData[1] ? dataRdVal[1] : READ_ZERO;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			smartHostN_q <= CTRL_RESET[SMART_BIT];
			controller_bank_request_q <= {CTRL_RESET[CONTROLLER_BANK_REQUEST_HIGH_BIT], CTRL_RESET[CONTROLLER_BANK_REQUEST_LOW_BIT]};
			hReq_q <= {CTRL_RESET[HREQ_HIGH_BIT], CTRL_RESET[HREQ_LOW_BIT]};
		end else begin
			smartHostN_q <= smartHostN_d;
			controller_bank_request_q <= controller_bank_request_d;
			hReq_q <= hReq_d;
		end
	end

	// ownership is exclusive per bank, so two writers never hit one byte
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 2; i++) begin
			if (dataWr[i]) begin
				mem_q[cmosAddr[i]] <= bus.wdata;
			end
		end
		if (hostWrOk) begin
			mem_q[hostCmosAddr] <= hostCmosWdata;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busRdata_q <= READ_ZERO;
			busRdValid_q <= 1'b0;
			hostCmosRdata <= READ_ZERO;
			hostCmosRdValid <= 1'b0;
		end else begin
			busRdValid_q <= bus.rd;
			if (bus.rd) begin
				busRdata_q <= busRdata_d;
			end
			hostCmosRdValid <= hostCmosRd;
			if (hostCmosRd) begin
				hostCmosRdata <= hostRdata_d;
			end
		end
	end

	// status copies lag the live state by one clock
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hostCtrlValue <= CTRL_RESET;
			hostGrant <= 2'b00;
			ctrlGrant <= 2'b00;
		end else begin
			hostCtrlValue <= ctrlValue;
			hostGrant <= hostOwn;
			ctrlGrant <= ctrlOwn;
		end
	end

	assign bus.rdata = busRdata_q;
	assign bus.rdValid = busRdValid_q;

endmodule // cmos_ram_shared_access_arbiter

// ---- sim/cmos_share_properties.sv ----
`timescale 1ns/1ps
module cmos_share_properties (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	input wire cmos_share_pkg::addr_t addr, // register address
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire cmos_share_pkg::byte_t wdata, // write byte
	input wire cmos_share_pkg::byte_t rdata, // read byte
	input wire logic rdValid // read byte valid
);
	import cmos_share_pkg::*;

	logic idxLow_q;
	logic idxHigh_q;
	wire lowData = (wr || rd) && addr == DATA_LOW_OFFSET;
	wire highData = (wr || rd) && addr == DATA_HIGH_OFFSET;
	wire ctrlRead = rd && addr == CTRL_OFFSET;

	////////////////////////////////////////////////////////////////////////////
	// a fresh index must precede each data access, stale ones may point anywhere
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) idxLow_q <= 1'b0;
		else if (wr && addr == IDX_LOW_OFFSET) idxLow_q <= 1'b1;
		else if (lowData) idxLow_q <= 1'b0;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) idxHigh_q <= 1'b0;
		else if (wr && addr == IDX_HIGH_OFFSET) idxHigh_q <= 1'b1;
		else if (highData) idxHigh_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	rdvalid_timing_a: assert property (rd |=> rdValid)
		else $error("read strobe not answered next cycle");
	rdvalid_cause_a: assert property (rdValid |-> $past(rd))
		else $error("read valid without a read");
	strobe_exclusive_a: assert property (!(wr && rd))
		else $error("read and write together");
	index_low_first_a: assert property (lowData |-> idxLow_q)
		else $error("low data access without fresh index");
	index_high_first_a: assert property (highData |-> idxHigh_q)
		else $error("high data access without fresh index");
	rdata_hold_a: assert property (!rdValid |-> $stable(rdata))
		else $error("read byte changed without valid");
	addr_mapped_a: assert property ((wr || rd) |-> addr inside {[CTRL_OFFSET:DATA_HIGH_OFFSET]})
		else $error("access outside register map");
	owner_exclusive_a: assert property (ctrlRead |=>
		!(rdata[HREQ_LOW_BIT] && rdata[CONTROLLER_BANK_REQUEST_LOW_BIT]) && !(rdata[HREQ_HIGH_BIT] && rdata[CONTROLLER_BANK_REQUEST_HIGH_BIT]))
		else $error("bank requested by both parties");

	cover property (lowData && wr);
	cover property (highData && rd);
	cover property (ctrlRead ##1 rdata[CONTROLLER_BANK_REQUEST_HIGH_BIT]);
endmodule // cmos_share_properties

// ---- sim/cmos_ram_shared_access_arbiter_tb.sv ----
`timescale 1ns/1ps
module cmos_ram_shared_access_arbiter_tb;
	import cmos_share_pkg::*;
	logic clk_sys, nrst, resetOutActive, secondarySupplyOn, hostReqWr, hostReqLow, hostReqHigh;
	logic hostCmosWr, hostCmosRd, hostCmosRdValid, avs_read, avs_write, avs_waitrequest;
	byte_t hostCmosAddr, hostCmosWdata, hostCmosRdata, hostCtrlValue;
	logic [1:0] hostGrant, ctrlGrant, avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	int n_fail, total_checks, smart, seed, k[2], h[2], mem[256];
	cmos_share_if bus();
	cmos_ram_shared_access_arbiter i_cmos_ram_shared_access_arbiter(.clk_sys, .nrst, .bus,
		.resetOutActive, .secondarySupplyOn, .hostReqWr, .hostReqLow, .hostReqHigh, .hostCmosWr,
		.hostCmosRd, .hostCmosAddr, .hostCmosWdata, .hostCmosRdata, .hostCmosRdValid,
		.hostCtrlValue, .hostGrant, .ctrlGrant);
	// short retry budget so the refused path ends quickly
	cmos_share_ctrl_agent #(.RETRY_MAX(2)) i_cmos_share_ctrl_agent(.clk_sys, .nrst, .bus,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	cmos_share_properties i_cmos_share_properties(.clk_sys, .nrst, .addr(bus.addr), .wr(bus.wr),
		.rd(bus.rd), .wdata(bus.wdata), .rdata(bus.rdata), .rdValid(bus.rdValid));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic byte_t cv();
		return 8'(smart * 128 + k[1] * 8 + h[1] * 4 + k[0] * 2 + h[0]);
	endfunction
	function automatic logic [1:0] cg();
		if (resetOutActive || !secondarySupplyOn) return 2'h3;
		return smart ? 2'h0 : 2'(k[1] * 2 + k[0]);
	endfunction
	function automatic logic [1:0] hg();
		if (resetOutActive || !secondarySupplyOn) return 2'h0;
		return 2'((smart | h[1]) * 2 + (smart | h[0]));
	endfunction
	function automatic int er(int b, int i);
		logic [1:0] g;
		g = cg();
		if (!g[b]) return 0;
		// only the low bank's last byte mirrors control, the high bank's is storage
		if (b == 0 && i % 128 == 127) return cv();
		return mem[b * 128 + i % 128];
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic state();
		repeat (2) @(posedge clk_sys);
		chk("control", 32'(hostCtrlValue), 32'(cv()));
		chk("host grant", 32'(hostGrant), 32'(hg()));
		chk("ctrl grant", 32'(ctrlGrant), 32'(cg()));
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic avs(logic w, logic [1:0] a, logic [31:0] d);
		int n;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 300);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 300) begin
			n_fail++;
			stop_test();
		end
		@(posedge clk_sys);
	endtask
	task automatic cmd(int op, int b, int i, int d);
		int n;
		avs(1'b1, AVS_CMD, 32'(smart * 2 ** 24 + d * 2 ** 16 + i * 2 ** 8 + b * 8 + op));
		n = 0;
		do begin
			avs(1'b0, AVS_STATUS, 32'h0000_0000);
			n++;
		end while (q[ST_BUSY] !== 1'b0 && n < 100);
		if (n >= 100) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic wrb(int b, int i, int d);
		logic [1:0] g;
		g = cg();
		cmd(OP_WRITE, b, i, d);
		if (g[b] && !(b == 0 && i % 128 == 127)) mem[b * 128 + i % 128] = d;
	endtask
	task automatic rdb(int b, int i);
		int e;
		e = er(b, i);
		cmd(OP_READ, b, i, 0);
		chk("ctrl byte", 32'(q[15:8]), 32'(e));
	endtask
	task automatic req(int b);
		int f;
		f = h[b];
		if (!f) k[b] = 1;
		cmd(OP_REQUEST, b, 0, 0);
		chk("req fail", 32'(q[ST_FAIL]), 32'(f));
		chk("req own", 32'(q[ST_OWN_LOW + b]), 32'(k[b]));
	endtask
	task automatic hreq(int lo, int hi);
		hostReqWr <= 1'b1;
		hostReqLow <= lo[0];
		hostReqHigh <= hi[0];
		@(posedge clk_sys);
		hostReqWr <= 1'b0;
		h[0] = lo && !smart && !k[0];
		h[1] = hi && !smart && !k[1];
		state();
	endtask
	task automatic hacc(logic w, byte_t a, byte_t d);
		logic [1:0] g;
		int e;
		g = hg();
		e = !g[a[7]] ? 0 : (a == MIRROR_INDEX) ? int'(cv()) : mem[a];
		hostCmosAddr <= a;
		hostCmosWdata <= d;
		hostCmosWr <= w;
		hostCmosRd <= !w;
		@(posedge clk_sys);
		hostCmosWr <= 1'b0;
		hostCmosRd <= 1'b0;
		@(posedge clk_sys);
		chk("host valid", 32'(hostCmosRdValid), 32'(!w));
		@(posedge clk_sys);
		if (w && g[a[7]] && a != MIRROR_INDEX) mem[a] = d;
		else if (!w) chk("host byte", 32'(hostCmosRdata), 32'(e));
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		int d;
		{nrst, resetOutActive, hostReqWr, hostReqLow, hostReqHigh, hostCmosWr, hostCmosRd} = '0;
		{avs_read, avs_write, avs_address, avs_writedata, hostCmosAddr, hostCmosWdata} = '0;
		secondarySupplyOn = 1'b1;
		smart = 1;
		k = '{0, 0};
		h = '{0, 0};
		n_fail = 0;
		total_checks = 0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		seed = $urandom(32'hd37f_8444);
		state();
		avs(1'b1, 2'h2, 32'hffff_ffff);
		avs(1'b0, 2'h2, 32'h0000_0000);
		chk("unmapped", q, 32'h0000_0000);
		avs(1'b0, AVS_STATUS, 32'h0000_0000);
		chk("smart", 32'(q[ST_SMART]), 32'h0000_0001);
		// an undefined op code is taken and must leave everything alone
		cmd(5, 0, 0, 0);
		state();
		resetOutActive <= 1'b1;
		state();
		wrb(0, 5, 165);
		rdb(0, 5);
		resetOutActive <= 1'b0;
		secondarySupplyOn <= 1'b0;
		state();
		wrb(1, 16, 60);
		rdb(1, 16);
		secondarySupplyOn <= 1'b1;
		smart = 0;
		cmd(OP_SMART, 0, 0, 0);
		state();
		hreq(1, 0);
		hreq(0, 0);
		req(0);
		state();
		hreq(1, 1);
		req(1);
		hacc(1'b1, 8'ha2, 8'h5a);
		hacc(1'b0, 8'ha2, 8'h00);
		rdb(1, 34);
		hreq(0, 0);
		req(1);
		rdb(1, 34);
		for (int j = 0; j < 6; j++) begin
			i = $urandom_range(126, 0);
			d = $urandom_range(255, 0);
			wrb(0, i + 128 * (j % 2), d);
			rdb(0, i + 128 * ((j + 1) % 2));
		end
		rdb(0, 127);
		wrb(0, 255, 17);
		rdb(0, 127);
		k[0] = 0;
		cmd(OP_RELEASE, 0, 0, 0);
		hreq(1, 0);
		req(0);
		smart = 1;
		h = '{0, 0};
		cmd(OP_SMART, 0, 0, 0);
		state();
		hacc(1'b1, 8'h7f, 8'h11);
		hacc(1'b0, 8'h7f, 8'h00);
		smart = 0;
		cmd(OP_SMART, 0, 0, 0);
		state();
		req(0);
		state();
		// host lacks the low bank now: its write is dropped and its read gives zero
		hacc(1'b1, 8'h05, 8'h33);
		hacc(1'b0, 8'h05, 8'h00);
		rdb(0, 5);
		stop_test();
	end
endmodule // cmos_ram_shared_access_arbiter_tb
